/* File: hdl/bias_dac_defs.svh */
/*
 * Offsets, field positions and reset values of the bias converter register block.
 * Assumes byte addressing on a 32-bit APB bus, one aligned word per register.
 */
`ifndef BIAS_DAC_DEFS_SVH
`define BIAS_DAC_DEFS_SVH

`define DAC_INPUT_CODE_OFFSET 12'h000
`define DAC_ENABLE_CONFIG_OFFSET 12'h004
`define DAC_CODE_RESET 8'h00
`define DAC_ENABLE_RESET 2'h0
`define DAC_CONV_ENABLE_BIT 0
`define DAC_AMP_ENABLE_BIT 1

`endif

/* File: hdl/bias_dac_pkg.sv */
/*
 * Types shared by the bias converter register block.
 * Assumes the constants header is included where offsets are needed.
 */
package bias_dac_pkg;
   typedef struct packed {
      logic amp_on;
      logic conv_on;
   } enable_type;

   typedef struct packed {
      logic [7:0] code;
      enable_type enable;
   } dac_ctrl_type;
endpackage : bias_dac_pkg

/* File: hdl/bias_dac_control_registers.sv */
/*
 * APB register block driving an 8-bit bias converter and its output amplifier.
 * Assumes an APB master on pclk; analog blocks sit outside and take the ctrl outputs.
 */
// Notes on behaviour
// - exactly two registers: code and enables
// - 8-bit rw code drives the converter
// - config bit 1 switches amplifier
// - config bit 0 switches converter independently
// - control block serves reads, writes, configuration
`timescale 1ns/100ps
`default_nettype none
`include "bias_dac_defs.svh"

module bias_dac_control_registers #(
   parameter int ADDR_WIDTH = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output bias_dac_pkg::dac_ctrl_type dac_ctrl
);

   // limitations: code and enables change at the edge where pready rises, a cycle before completion,
   // so the analog side may start settling while the bus cycle is open.
   // only byte lane 0 gates writes; lanes 1 to 3 carry nothing stored.
   // unmapped offsets answer with pslverr and leave both registers alone.

   // bus timing, cycle by cycle:
   //   setup edge   - psel high, penable low; write lands in the registers
   //   access cycle - pready, pslverr and read data stand for one cycle
   //   next edge    - master completes and may start the next setup
   // a fixed zero-wait response keeps the slave free of any counter state.

   // value both registers take on system reset
   localparam bias_dac_pkg::dac_ctrl_type CTRL_RESET =
      {`DAC_CODE_RESET, `DAC_ENABLE_RESET};

   // stored state: conversion code and the two enables
   bias_dac_pkg::dac_ctrl_type ctrl_reg;
   bias_dac_pkg::dac_ctrl_type ctrl_next;

   // bus response state; all three leave the block from flops
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic pready_reg;
   logic pready_next;

   // qualifiers of the current bus cycle
   logic setup;
   logic write_setup;
   logic read_setup;
   logic byte0_en;
   logic hit_code;
   logic hit_cfg;
   logic hit_any;

   // decode helpers are shared by the write path and the read path,
   // so both always agree on which word an address selects

   // true when the word address selects the conversion code
   function automatic logic is_code_addr(
      input logic [ADDR_WIDTH-1:0] addr
   );
      logic hit;
      hit = (addr == ADDR_WIDTH'(`DAC_INPUT_CODE_OFFSET));
      return hit;
   endfunction : is_code_addr

   // true when the word address selects the enable configuration
   function automatic logic is_cfg_addr(
      input logic [ADDR_WIDTH-1:0] addr
   );
      logic hit;
      hit = (addr == ADDR_WIDTH'(`DAC_ENABLE_CONFIG_OFFSET));
      return hit;
   endfunction : is_cfg_addr

   // exactly two words answer; everything else is an error
   function automatic logic is_mapped(
      input logic [ADDR_WIDTH-1:0] addr
   );
      logic hit;
      hit = is_code_addr(addr) || is_cfg_addr(addr);
      return hit;
   endfunction : is_mapped

   // only the low byte lane holds stored bits
   function automatic logic lane0_written(
      input logic [3:0] strb
   );
      logic lane;
      lane = strb[0];
      return lane;
   endfunction : lane0_written

   // new enables from a written word; upper bits are dropped
   function automatic bias_dac_pkg::enable_type merge_enable(
      input logic [31:0] wdata
   );
      bias_dac_pkg::enable_type en;
      en.amp_on = wdata[`DAC_AMP_ENABLE_BIT];
      en.conv_on = wdata[`DAC_CONV_ENABLE_BIT];
      return en;
   endfunction : merge_enable

   // read word of the conversion code
   function automatic logic [31:0] code_word(
      input bias_dac_pkg::dac_ctrl_type ctrl
   );
      logic [31:0] word;
      word = {24'h00_0000, ctrl.code};
      return word;
   endfunction : code_word

   // read word of the enables; bits 7..2 are not stored, so read zero
   function automatic logic [31:0] cfg_word(
      input bias_dac_pkg::dac_ctrl_type ctrl
   );
      logic [31:0] word;
      word = {30'h0000_0000, ctrl.enable};
      return word;
   endfunction : cfg_word

   // read value of one word
   function automatic logic [31:0] read_word(
      input logic [ADDR_WIDTH-1:0] addr,
      input bias_dac_pkg::dac_ctrl_type ctrl
   );
      logic [31:0] word;
      word = 32'h0000_0000;
      if (is_code_addr(addr)) begin
         word = code_word(ctrl);
      end else if (is_cfg_addr(addr)) begin
         word = cfg_word(ctrl);
      end else begin
         word = 32'h0000_0000;
      end
      return word;
   endfunction : read_word

   // zero-wait slave: the answer stands in the access cycle after setup
   assign setup = psel && !penable;
   assign write_setup = setup && pwrite;
   assign read_setup = setup && !pwrite;
   // a write to a mapped word without the low byte lane is ignored, with no error
   assign byte0_en = lane0_written(pstrb);
   assign hit_code = is_code_addr(paddr);
   assign hit_cfg = is_cfg_addr(paddr);
   assign hit_any = is_mapped(paddr);

   // control group: next code and enables
   always_comb begin
      ctrl_next = ctrl_reg;
      if (write_setup && byte0_en) begin
         if (hit_code) begin
            ctrl_next.code = pwdata[7:0];
         end else if (hit_cfg) begin
            ctrl_next.enable = merge_enable(pwdata);
         end else begin
            ctrl_next = ctrl_reg;
         end
      end
   end

   // write commits at the setup edge, one cycle ahead of completion;
   // the converter sees the new code while the access phase still runs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= CTRL_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // response group: ready, error and read data for the access cycle
   always_comb begin
      pready_next = setup;
      pslverr_next = 1'b0;
      prdata_next = 32'h0000_0000;
      if (setup) begin
         if (!hit_any) begin
            pslverr_next = 1'b1;
         end else if (read_setup) begin
            prdata_next = read_word(paddr, ctrl_reg);
         end else begin
            // write cycles return zero so stale data never leaks
            prdata_next = 32'h0000_0000;
         end
      end
   end

   // read data outside the access cycle is zero, never a stale word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
         pready_reg <= 1'b0;
      end else begin
         prdata_reg <= prdata_next;
         pslverr_reg <= pslverr_next;
         pready_reg <= pready_next;
      end
   end

   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg;
   assign pready = pready_reg;
   assign dac_ctrl = ctrl_reg;

endmodule : bias_dac_control_registers
`default_nettype wire

/* File: testbench/bias_dac_control_registers_asserts.sv */
/* checker for the register block; bound to its ports */
`timescale 1ns/100ps
`default_nettype none
module bdc_chk(input wire logic pclk,presetn,psel,penable,pwrite,pready,pslverr,
input wire logic [11:0] paddr,input wire logic [31:0] pwdata,prdata,input wire logic [3:0] pstrb,
input wire bias_dac_pkg::dac_ctrl_type dac_ctrl);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
wire logic su=psel&&!penable;
a_ready_next: assert property(su|=>pready) else $error("no ready");
a_code_wr: assert property(su&&pwrite&&pstrb[0]&&paddr==0|=>dac_ctrl.code==$past(pwdata[7:0]))
 else $error("code");
a_en_wr: assert property(su&&pwrite&&pstrb[0]&&paddr==4|=>dac_ctrl.enable==$past(pwdata[1:0]))
 else $error("enable");
a_cfg_zero: assert property(pready&&!pwrite&&paddr==4|->prdata[31:2]==0) else $error("cfg");
a_unmapped: assert property(pready&&paddr>4|->pslverr) else $error("slverr");
a_reset_val: assert property($rose(presetn)|->dac_ctrl==0) else $error("reset");
cover property(pslverr);
cover property(dac_ctrl.enable==3);
cover property(dac_ctrl.code==8'hff);
endmodule : bdc_chk
bind bias_dac_control_registers bdc_chk c(.*);
`default_nettype wire

/* File: testbench/apb_host.sv */
/* processor side apb master; assumes pclk from the bench */
`timescale 1ns/100ps
`default_nettype none
module apb_host(input wire logic pclk,pready,pslverr,input wire logic [31:0] prdata,
output logic psel=0,penable=0,pwrite=0,output logic [11:0] paddr=0,output logic [31:0] pwdata=0);
logic [31:0] r;
logic e;
task x(input logic w,input logic [11:0] a,input logic [31:0] d);
@(posedge pclk) {psel,pwrite,paddr,pwdata}<={1'b1,w,a,d};
@(posedge pclk) penable<=1;
do @(posedge pclk); while(pready!==1);
r=prdata;
e=pslverr;
{psel,penable}<=0;
pwdata<=~d; // released bus must not echo
endtask : x
endmodule : apb_host
`default_nettype wire

/* File: testbench/bias_dac_control_registers_tb_top.sv */
/* bench for the register block; host model in apb_host */
`timescale 1ns/100ps
`default_nettype none
module bias_dac_control_registers_tb_top;
logic pclk=0,presetn=0,psel,penable,pwrite,pready,pslverr;
logic [11:0] paddr;
logic [31:0] pwdata,prdata;
bias_dac_pkg::dac_ctrl_type dac_ctrl;
int miscompares=0,n_compared=0;
always #12.5 pclk=~pclk;
apb_host h(.*);
bias_dac_control_registers uut(.*,.pstrb(4'hf));
task chk(input logic [31:0] g,e);
n_compared++;
if(g!==e) begin miscompares++; $display("MISMATCH %0t %h %h",$time,g,e); end
endtask : chk
task end_of_test;
$display("compared %0d mismatched %0d",n_compared,miscompares);
if(miscompares==0&&n_compared>0) $display("DONE - PASS");
else $display("DONE - FAIL");
$finish;
endtask : end_of_test
initial begin #20000; miscompares++; end_of_test; end
initial begin
repeat(6) @(posedge pclk);
presetn<=1;
h.x(0,0,0); chk(h.r,0);
h.x(0,4,0); chk(h.r,0);
$display("reset value test done");
h.x(1,0,'1); h.x(0,0,0); chk(h.r,32'hff); chk(dac_ctrl.code,32'hff);
$display("code test done");
for(int i=0;i<4;i++) begin
h.x(1,4,~32'd3|i); chk(dac_ctrl.enable,i);
h.x(0,4,0); chk(h.r,i);
end
$display("enable test done");
@(posedge pclk) presetn<=0;
repeat(2) @(posedge pclk);
chk(dac_ctrl,0);
presetn<=1;
h.x(0,0,0); chk(h.r,0);
h.x(0,4,0); chk(h.r,0);
$display("mid-run reset test done");
h.x(1,8,1); chk(h.e,1);
$display("register tests done");
end_of_test;
end
endmodule : bias_dac_control_registers_tb_top
`default_nettype wire
